// [l1cc_top.sv]
// Purpose: L1 cache control: icache enable/lock/flash, dcache flush walk,
//          cache-management broadcast/snoop and touch prefetch handling
// Assumes: Inputs synchronous to clk_i; power-up equals hard reset
// Notes: Tag arrays are valid bits only; data paths live elsewhere
// How it works
// - Icache enable clears at reset; a fetch barrier precedes changes.
// - Disabled icache ignores tags; every fetch goes out single-beat.
// - Cache-inhibit output follows the access attribute only.
// - Icache block invalidate works whether or not icache is enabled.
// - Locked icache allocates nothing; snoop hits, block and flash invalidates clear tags.
// - Locked: hits served; misses burst 32 bytes, fill L2 unless data-only.
// - Flash invalidate empties icache, no broadcast; self-clears if enabled.
// - Hard reset invalidates icache; soft reset does not.
// - Dcache hardware flush starts only on a 0 to 1 write of its bit.
// - Walk indexes zero to max in way 0, then ways 1 to 7.
// - Modified lines: non-global write-with-kill; all lines end invalid.
// - Flush stalls dcache requests while snoops are still serviced.
// - Flush bit clears once the walk ends at way 7, index max; writebacks may still queue.
// - Global cache-management broadcasts from other masters are snooped.
// - Dcache store/flush/invalidate broadcast if coherent; icache op always.
// - Any cache-management op to a direct-store segment is a no-op.
// - Touch to direct-store or with nop-select set: no translation at all.
// - Other touches translate and check protection like a byte load.
// - Touch no-ops on failed translation or load, inhibit, lock, disable.
// - Valid touch checks L1, then L2, then bursts without intent to modify.
// - Touch fill is exclusive or shared; sets reference and replacement.
`timescale 1ns/1ps
`include "l1cc_consts.svh"
module l1cc_top
   import l1cc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic soft_reset_i,
   // AXI4-Lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Instruction fetch and cache-management requests
   input wire l1cc_fetch_t fetch_i,
   input wire l1cc_cmo_t cmo_i,
   input wire logic dc_req_i,
   output logic dc_stall_o,
   // Dcache state seen by the walk
   input wire logic [255:0] dc_valid_i,
   input wire logic [255:0] dc_mod_i,
   output logic dc_line_inv_o,
   output logic [`L1CC_IDX_W-1:0] dc_idx_o,
   output logic [`L1CC_WAY_W-1:0] dc_way_o,
   // Snoop side
   input wire logic snoop_valid_i,
   input wire logic snoop_global_i,
   input wire logic snoop_iinv_i,
   input wire logic [31:0] snoop_addr_i,
   output logic snoop_take_o,
   // Touch results
   output logic touch_xlate_o,
   output logic touch_ref_set_o,
   output logic touch_l2_look_o,
   output logic touch_fill_excl_o,
   output logic touch_fill_o,
   // System bus request
   output l1cc_bus_t bus_o,
   output logic cache_inhibit_out_o,
   output logic global_out_o
);
   // Icache index is addr[11:5] for 128 sets
   localparam int IC_SETS = 128;

   logic [31:0] cfg0_ff, nxt_cfg0;
   logic hwf_ff, nxt_hwf;
   logic l2_donly_ff, nxt_l2_donly;
   logic [IC_SETS-1:0] ic_valid_ff, nxt_ic_valid;
   l1cc_fl_state_t fl_ff, nxt_fl;
   logic [`L1CC_IDX_W-1:0] idx_ff, nxt_idx;
   logic [`L1CC_WAY_W-1:0] way_ff, nxt_way;
   logic bvalid_ff, nxt_bvalid;
   logic rvalid_ff, nxt_rvalid;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0] bresp_ff, nxt_bresp;
   logic [1:0] rresp_ff, nxt_rresp;
   l1cc_bus_t bus_ff, nxt_bus;
   logic [4:0] touch_ff, nxt_touch;

   function automatic logic [6:0] ic_set(input logic [31:0] a);
      ic_set = a[11:5];
   endfunction

   function automatic logic is_reg(input logic [11:0] a, input logic [11:0] o);
      is_reg = (a[11:2] == o[11:2]);
   endfunction

   logic wr_go, rd_go, ic_en, ic_lock, dcache_on, walk_done;
   logic [7:0] line_sel;
   assign ic_en = cfg0_ff[`L1CC_CFG0_IC_EN];
   assign ic_lock = cfg0_ff[`L1CC_CFG0_IC_LOCK];
   assign dcache_on = cfg0_ff[`L1CC_CFG0_DC_EN] &
                      ~cfg0_ff[`L1CC_CFG0_DC_LOCK];
   assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
   assign rd_go = s_axi_arvalid & ~rvalid_ff;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign line_sel = {way_ff, idx_ff[4:0]} ^ {3'h0, idx_ff[6:5], 3'h0};
   assign walk_done = (idx_ff == `L1CC_IDX_MAX) && (way_ff == `L1CC_WAY_MAX);

   // Register bus
   always_comb begin
      nxt_bvalid = bvalid_ff & ~s_axi_bready;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff & ~s_axi_rready;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (wr_go) begin
         nxt_bvalid = 1'b1;
         nxt_bresp = (is_reg(s_axi_awaddr, `L1CC_OFF_CFG0) ||
                      is_reg(s_axi_awaddr, `L1CC_OFF_MEMSYS0) ||
                      is_reg(s_axi_awaddr, `L1CC_OFF_L2CTL) ||
                      is_reg(s_axi_awaddr, `L1CC_OFF_STATUS)) ?
                     `L1CC_RESP_OKAY : `L1CC_RESP_SLVERR;
      end
      if (rd_go) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = `L1CC_RESP_OKAY;
         nxt_rdata = 32'h0000_0000;
         if (is_reg(s_axi_araddr, `L1CC_OFF_CFG0)) begin
            nxt_rdata = cfg0_ff;
         end else if (is_reg(s_axi_araddr, `L1CC_OFF_MEMSYS0)) begin
            nxt_rdata[`L1CC_MS0_HWF] = hwf_ff;
         end else if (is_reg(s_axi_araddr, `L1CC_OFF_L2CTL)) begin
            nxt_rdata[`L1CC_L2_DO] = l2_donly_ff;
         end else if (is_reg(s_axi_araddr, `L1CC_OFF_STATUS)) begin
            nxt_rdata[`L1CC_ST_FLUSHING] = (fl_ff == L1CC_FL_WALK);
            nxt_rdata[`L1CC_ST_IC_VALID] = |ic_valid_ff;
            nxt_rdata[`L1CC_ST_DC_ANYV] = |dc_valid_i;
         end else begin
            nxt_rresp = `L1CC_RESP_SLVERR;
         end
      end
   end

   // Control registers and dcache flush walk
   always_comb begin
      nxt_cfg0 = cfg0_ff;
      nxt_hwf = hwf_ff;
      nxt_l2_donly = l2_donly_ff;
      nxt_fl = fl_ff;
      nxt_idx = idx_ff;
      nxt_way = way_ff;
      if (cfg0_ff[`L1CC_CFG0_IC_FLASH] && ic_en) begin
         nxt_cfg0[`L1CC_CFG0_IC_FLASH] = 1'b0;
      end
      if (wr_go && s_axi_wstrb[0]) begin
         if (is_reg(s_axi_awaddr, `L1CC_OFF_CFG0)) begin
            nxt_cfg0 = {26'h0, s_axi_wdata[5:0]};
         end else if (is_reg(s_axi_awaddr, `L1CC_OFF_L2CTL)) begin
            nxt_l2_donly = s_axi_wdata[`L1CC_L2_DO];
         end else if (is_reg(s_axi_awaddr, `L1CC_OFF_MEMSYS0) &&
                      s_axi_wdata[`L1CC_MS0_HWF] && !hwf_ff) begin
            nxt_hwf = 1'b1;
         end
      end
      case (fl_ff)
         L1CC_FL_IDLE: begin
            if (nxt_hwf && !hwf_ff) begin
               nxt_fl = L1CC_FL_WALK;
               nxt_idx = '0;
               nxt_way = '0;
            end
         end
         L1CC_FL_WALK: begin
            // Writes to the flush bit do not restart the walk
            if (walk_done) begin
               nxt_fl = L1CC_FL_IDLE;
               nxt_hwf = 1'b0;
            end else if (idx_ff == `L1CC_IDX_MAX) begin
               nxt_idx = '0;
               nxt_way = way_ff + 3'h1;
            end else begin
               nxt_idx = idx_ff + 7'h01;
            end
         end
         default: begin
            nxt_fl = L1CC_FL_IDLE;
         end
      endcase
   end

   // Icache tag valid bits
   always_comb begin
      nxt_ic_valid = ic_valid_ff;
      if (fetch_i.valid && ic_en && !ic_lock && !fetch_i.inhibit &&
          !fetch_i.tag_hit) begin
         nxt_ic_valid[ic_set(fetch_i.addr)] = 1'b1;
      end
      if (cmo_i.valid && cmo_i.op == L1CC_OP_IINV && !cmo_i.seg_direct) begin
         nxt_ic_valid[ic_set(cmo_i.addr)] = 1'b0;
      end
      if (snoop_take_o && snoop_iinv_i) begin
         nxt_ic_valid[ic_set(snoop_addr_i)] = 1'b0;
      end
      if (cfg0_ff[`L1CC_CFG0_IC_FLASH]) begin
         nxt_ic_valid = '0;
      end
      if (soft_reset_i) begin
         nxt_ic_valid = ic_valid_ff;
      end
   end

   // Bus requests: fetches, flush write-with-kill, broadcasts, touch reads
   logic cmo_live, tch_nop_early, tch_ok;
   assign cmo_live = cmo_i.valid && !cmo_i.seg_direct;
   assign tch_nop_early = cmo_i.seg_direct ||
                          cfg0_ff[`L1CC_CFG0_TCH_NOP];
   assign tch_ok = cmo_i.valid && cmo_i.op == L1CC_OP_TCH &&
                   !tch_nop_early && cmo_i.xlate_ok && cmo_i.load_ok &&
                   !cmo_i.inhibit && dcache_on;
   always_comb begin
      nxt_bus = '0;
      nxt_touch = '0;
      if (fl_ff == L1CC_FL_WALK) begin
         if (dc_valid_i[line_sel] && dc_mod_i[line_sel]) begin
            nxt_bus.valid = 1'b1;
            nxt_bus.wr_kill = 1'b1;
            nxt_bus.bytes = `L1CC_BURST_BYTES;
            nxt_bus.addr = {20'h0, idx_ff, 5'h00};
         end
      end else if (fetch_i.valid && (!ic_en || fetch_i.inhibit)) begin
         nxt_bus.valid = 1'b1;
         nxt_bus.addr = fetch_i.addr;
         nxt_bus.bytes = `L1CC_SINGLE_BYTES;
      end else if (fetch_i.valid && !fetch_i.tag_hit) begin
         nxt_bus.valid = 1'b1;
         nxt_bus.addr = {fetch_i.addr[31:5], 5'h00};
         nxt_bus.bytes = `L1CC_BURST_BYTES;
         nxt_bus.fill_icache = !ic_lock;
         nxt_bus.fill_l2 = !(ic_lock && l2_donly_ff);
      end else if (cmo_live && ((cmo_i.op == L1CC_OP_IINV) ||
               (cmo_i.coherent && (cmo_i.op == L1CC_OP_DST ||
               cmo_i.op == L1CC_OP_DFL || cmo_i.op == L1CC_OP_DINV)))) begin
         nxt_bus.valid = 1'b1;
         nxt_bus.global = 1'b1;
         nxt_bus.addr = {cmo_i.addr[31:5], 5'h00};
      end else if (tch_ok && !cmo_i.l1_hit && !cmo_i.l2_hit) begin
         nxt_bus.valid = 1'b1;
         nxt_bus.addr = {cmo_i.addr[31:5], 5'h00};
         nxt_bus.bytes = `L1CC_BURST_BYTES;
         nxt_bus.intent_mod = 1'b0;
         nxt_bus.fill_l2 = 1'b1;
      end
      if (cmo_i.valid && cmo_i.op == L1CC_OP_TCH && !tch_nop_early) begin
         nxt_touch[0] = 1'b1;
         // Reference bit is set even when a translated touch no-ops
         nxt_touch[1] = 1'b1;
      end
      if (tch_ok) begin
         nxt_touch[2] = !cmo_i.l1_hit;
         nxt_touch[3] = !cmo_i.shared && !cmo_i.l1_hit;
         nxt_touch[4] = !cmo_i.l1_hit;
      end
      nxt_bus.inhibit = fetch_i.inhibit;
   end

   assign dc_stall_o = dc_req_i && (fl_ff == L1CC_FL_WALK);
   assign snoop_take_o = snoop_valid_i && snoop_global_i;
   assign dc_line_inv_o = (fl_ff == L1CC_FL_WALK);
   assign dc_idx_o = idx_ff;
   assign dc_way_o = way_ff;
   assign bus_o = bus_ff;
   assign cache_inhibit_out_o = bus_ff.inhibit;
   assign global_out_o = bus_ff.global;
   assign touch_xlate_o = touch_ff[0];
   assign touch_ref_set_o = touch_ff[1];
   assign touch_l2_look_o = touch_ff[2];
   assign touch_fill_excl_o = touch_ff[3];
   assign touch_fill_o = touch_ff[4];

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cfg0_ff <= `L1CC_CFG0_RST;
         hwf_ff <= 1'b0;
         l2_donly_ff <= 1'b0;
         ic_valid_ff <= '0;
         fl_ff <= L1CC_FL_IDLE;
         idx_ff <= '0;
         way_ff <= '0;
         bvalid_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         bresp_ff <= `L1CC_RESP_OKAY;
         rresp_ff <= `L1CC_RESP_OKAY;
         bus_ff <= '0;
         touch_ff <= '0;
      end else begin
         cfg0_ff <= nxt_cfg0;
         hwf_ff <= nxt_hwf;
         l2_donly_ff <= nxt_l2_donly;
         ic_valid_ff <= nxt_ic_valid;
         fl_ff <= nxt_fl;
         idx_ff <= nxt_idx;
         way_ff <= nxt_way;
         bvalid_ff <= nxt_bvalid;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         bresp_ff <= nxt_bresp;
         rresp_ff <= nxt_rresp;
         bus_ff <= nxt_bus;
         touch_ff <= nxt_touch;
      end
   end
endmodule

// [l1cc_consts.svh]
// Purpose: Offsets, field positions, reset values and counts for l1cc
// Assumes: AXI4-Lite 32-bit word registers
// Notes: Included by the package users only
`ifndef L1CC_CONSTS_SVH
`define L1CC_CONSTS_SVH
`define L1CC_OFF_CFG0     12'h000
`define L1CC_OFF_MEMSYS0  12'h004
`define L1CC_OFF_L2CTL    12'h008
`define L1CC_OFF_STATUS   12'h00C
`define L1CC_CFG0_IC_EN    0
`define L1CC_CFG0_IC_LOCK  1
`define L1CC_CFG0_IC_FLASH 2
`define L1CC_CFG0_DC_EN    3
`define L1CC_CFG0_DC_LOCK  4
`define L1CC_CFG0_TCH_NOP  5
`define L1CC_MS0_HWF      0
`define L1CC_L2_DO        0
`define L1CC_ST_FLUSHING  0
`define L1CC_ST_IC_VALID  1
`define L1CC_ST_DC_ANYV   2
`define L1CC_CFG0_RST     32'h0000_0000
`define L1CC_IDX_W        7
`define L1CC_WAY_W        3
`define L1CC_IDX_MAX      7'h7F
`define L1CC_WAY_MAX      3'h7
`define L1CC_BURST_BYTES  6'h20
`define L1CC_SINGLE_BYTES 6'h04
`define L1CC_RESP_OKAY    2'h0
`define L1CC_RESP_SLVERR  2'h2
`endif

// [l1cc_pkg.sv]
// Purpose: Types shared by the l1cc block and its bench
// Assumes: Constants live in l1cc_consts.svh
// Notes: Structs carry grouped request and bus signals
package l1cc_pkg;
   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic        inhibit;
      logic        tag_hit;
   } l1cc_fetch_t;
   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic [5:0]  bytes;
      logic        inhibit;
      logic        global;
      logic        fill_icache;
      logic        fill_l2;
      logic        wr_kill;
      logic        intent_mod;
   } l1cc_bus_t;
   typedef enum logic [2:0] {
      L1CC_OP_NONE = 3'h0,
      L1CC_OP_DST  = 3'h1,
      L1CC_OP_DFL  = 3'h2,
      L1CC_OP_DINV = 3'h3,
      L1CC_OP_IINV = 3'h4,
      L1CC_OP_TCH  = 3'h5
   } l1cc_op_t;
   typedef struct packed {
      logic        valid;
      l1cc_op_t    op;
      logic [31:0] addr;
      logic        coherent;
      logic        seg_direct;
      logic        xlate_ok;
      logic        load_ok;
      logic        inhibit;
      logic        l1_hit;
      logic        l2_hit;
      logic        shared;
   } l1cc_cmo_t;
   typedef enum logic [1:0] {
      L1CC_FL_IDLE = 2'b01,
      L1CC_FL_WALK = 2'b10
   } l1cc_fl_state_t;
endpackage

// [l1cc_sysbus_model.sv]
// Purpose: System bus with memory and another coherent master
// Assumes: Requests arrive as one-cycle pulses on bus_i
// Notes: Snoop address toggles while no broadcast is under way
`timescale 1ns/1ps
module l1cc_sysbus_model
   import l1cc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Block side
   input wire l1cc_bus_t bus_i,
   input wire logic snoop_cmd_i,
   output logic snoop_valid_o,
   output logic snoop_global_o,
   output logic snoop_iinv_o,
   output logic [31:0] snoop_addr_o
);
   int n_req = 0;
   int n_kill = 0;
   initial begin
      snoop_valid_o = 1'b0;
      snoop_global_o = 1'b0;
      snoop_iinv_o = 1'b0;
      snoop_addr_o = 32'h0000_0000;
   end
   always @(posedge clk_i) begin
      if (!reset_i && bus_i.valid) begin
         n_req <= n_req + 1;
         n_kill <= n_kill + int'(bus_i.wr_kill);
      end
      // Global icache invalidate from the other master
      snoop_valid_o <= snoop_cmd_i;
      snoop_global_o <= snoop_cmd_i;
      snoop_iinv_o <= snoop_cmd_i;
      snoop_addr_o <= snoop_cmd_i ? 32'h0000_1000 : ~snoop_addr_o;
   end
endmodule

// [l1cc_chk.sv]
// Purpose: Port assertions for l1cc_top
// Assumes: One clock domain
// Notes: Attached by bind at the foot
`timescale 1ns/1ps
`include "l1cc_consts.svh"
module l1cc_chk
   import l1cc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Watched ports
   input wire l1cc_fetch_t fetch_i,
   input wire l1cc_cmo_t cmo_i,
   input wire logic dc_req_i,
   input wire logic dc_stall_o,
   input wire logic dc_line_inv_o,
   input wire logic [6:0] dc_idx_o,
   input wire logic [2:0] dc_way_o,
   input wire logic snoop_valid_i,
   input wire logic snoop_global_i,
   input wire logic snoop_take_o,
   input wire logic touch_xlate_o,
   input wire logic touch_ref_set_o,
   input wire l1cc_bus_t bus_o,
   input wire logic cache_inhibit_out_o,
   input wire logic global_out_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   property p_stall;
      dc_stall_o == (dc_req_i && dc_line_inv_o);
   endproperty
   a_stall: assert property (p_stall) else $error("stall wrong");
   property p_snoop;
      snoop_valid_i && snoop_global_i |-> snoop_take_o;
   endproperty
   a_snoop: assert property (p_snoop) else $error("snoop lost");
   property p_step;
      dc_line_inv_o && dc_idx_o != `L1CC_IDX_MAX |=> dc_line_inv_o &&
         dc_idx_o == $past(dc_idx_o) + 7'h01 && $stable(dc_way_o);
   endproperty
   a_step: assert property (p_step) else $error("index step");
   property p_wrap;
      dc_line_inv_o && dc_idx_o == `L1CC_IDX_MAX && dc_way_o != `L1CC_WAY_MAX
         |=> dc_idx_o == 7'h00 && dc_way_o == $past(dc_way_o) + 3'h1;
   endproperty
   a_wrap: assert property (p_wrap) else $error("way step");
   property p_start;
      $rose(dc_line_inv_o) |-> dc_idx_o == 7'h00 && dc_way_o == 3'h0;
   endproperty
   a_start: assert property (p_start) else $error("walk start");
   property p_end;
      dc_line_inv_o && dc_idx_o == `L1CC_IDX_MAX && dc_way_o == `L1CC_WAY_MAX
         |=> !dc_line_inv_o;
   endproperty
   a_end: assert property (p_end) else $error("walk end");
   property p_kill;
      bus_o.valid && bus_o.wr_kill |-> !global_out_o &&
         bus_o.bytes == `L1CC_BURST_BYTES && $past(dc_line_inv_o);
   endproperty
   a_kill: assert property (p_kill) else $error("kill form");
   property p_inh;
      fetch_i.valid && fetch_i.inhibit && !dc_line_inv_o |=> bus_o.valid &&
         cache_inhibit_out_o && bus_o.bytes == `L1CC_SINGLE_BYTES;
   endproperty
   a_inh: assert property (p_inh) else $error("inhibit fetch");
   property p_iinv;
      cmo_i.valid && cmo_i.op == L1CC_OP_IINV && !cmo_i.seg_direct &&
         !fetch_i.valid && !dc_line_inv_o |=> bus_o.valid && global_out_o;
   endproperty
   a_iinv: assert property (p_iinv) else $error("iinv cast");
   property p_direct;
      cmo_i.valid && cmo_i.seg_direct && !fetch_i.valid && !dc_line_inv_o
         |=> !touch_xlate_o && !touch_ref_set_o && !bus_o.valid;
   endproperty
   a_direct: assert property (p_direct) else $error("direct");
endmodule
bind l1cc_top l1cc_chk l1cc_chk_inst(.clk_i, .reset_i, .fetch_i, .cmo_i,
   .dc_req_i, .dc_stall_o, .dc_line_inv_o, .dc_idx_o, .dc_way_o,
   .snoop_valid_i, .snoop_global_i, .snoop_take_o, .touch_xlate_o,
   .touch_ref_set_o, .bus_o, .cache_inhibit_out_o, .global_out_o);

// [l1cc_tb.sv]
// Purpose: Self-checking bench for l1cc_top
// Assumes: AXI4-Lite master tasks, bus partner model
// Notes: Each scenario judges its own results
`timescale 1ns/1ps
`include "l1cc_consts.svh"
module tb
   import l1cc_pkg::*;
;
   logic clk_i = 1'b0, reset_i = 1'b1, soft_reset_i = 1'b0, snoop_cmd = 1'b0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, snoop_addr_i;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, dc_req_i = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, dc_stall_o, dc_line_inv_o, snoop_take_o;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   l1cc_fetch_t fetch_i = '0;
   l1cc_cmo_t cmo_i = '0;
   l1cc_bus_t bus_o;
   logic [255:0] dc_valid_i = '0, dc_mod_i = '0;
   logic [6:0] dc_idx_o;
   logic [2:0] dc_way_o;
   logic snoop_valid_i, snoop_global_i, snoop_iinv_i, touch_fill_o;
   logic touch_xlate_o, touch_ref_set_o, touch_l2_look_o, touch_fill_excl_o;
   logic cache_inhibit_out_o, global_out_o;
   int errors = 0, n_compared = 0;
   // Touch cases: inputs {seg,xlate,load,inh,l1,l2,shared}, results
   localparam logic [15:0] TT [7] = '{16'h7000, 16'h1030, 16'h2030,
      16'h3830, 16'h3430, 16'h333C, 16'h303F};
   localparam logic [15:0] TC [3] = '{16'h2800, 16'h1830, 16'h0030};
   always #12.5 clk_i = ~clk_i;
   l1cc_top l1cc_top_inst(.clk_i, .reset_i, .soft_reset_i, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fetch_i,
      .cmo_i, .dc_req_i, .dc_stall_o, .dc_valid_i, .dc_mod_i,
      .dc_line_inv_o, .dc_idx_o, .dc_way_o, .snoop_valid_i, .snoop_global_i,
      .snoop_iinv_i, .snoop_addr_i, .snoop_take_o, .touch_xlate_o,
      .touch_ref_set_o, .touch_l2_look_o, .touch_fill_excl_o, .touch_fill_o,
      .bus_o, .cache_inhibit_out_o, .global_out_o);
   l1cc_sysbus_model l1cc_sysbus_model_inst(.clk_i, .reset_i, .bus_i(bus_o),
      .snoop_cmd_i(snoop_cmd), .snoop_valid_o(snoop_valid_i),
      .snoop_global_o(snoop_global_i), .snoop_iinv_o(snoop_iinv_i),
      .snoop_addr_o(snoop_addr_i));
   task conclude;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [33:0] g, input logic [33:0] e);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(ta && tw)) begin
         @(posedge clk_i);
         if (s_axi_awvalid && s_axi_awready) begin
            ta = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            tw = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      do @(posedge clk_i); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk_i); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge clk_i); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task rchk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk({r, d}, {`L1CC_RESP_OKAY, e});
   endtask
   function automatic l1cc_fetch_t fe(input logic inh, input logic hit);
      return {1'b1, 32'h0000_1000, inh, hit};
   endfunction
   function automatic l1cc_cmo_t cm(input l1cc_op_t op, input logic coh,
      input logic [6:0] b);
      return {1'b1, op, 32'h0000_2000, coh, b};
   endfunction
   task go(input l1cc_fetch_t f, input l1cc_cmo_t c);
      @(posedge clk_i);
      fetch_i <= f;
      cmo_i <= c;
      @(posedge clk_i);
      fetch_i <= '0;
      cmo_i <= '0;
      #1;
   endtask
   task tch(input logic [6:0] b, input logic [5:0] e);
      go('0, cm(L1CC_OP_TCH, 1'b0, b));
      chk({touch_xlate_o, touch_ref_set_o, touch_l2_look_o, touch_fill_o,
         touch_fill_excl_o, bus_o.valid}, e);
      if (e[0])
         chk({bus_o.intent_mod, bus_o.bytes},
            {1'b0, `L1CC_BURST_BYTES});
   endtask
   task t_reset;
      logic [31:0] d;
      logic [1:0] r;
      rchk(`L1CC_OFF_CFG0, `L1CC_CFG0_RST);
      rchk(`L1CC_OFF_STATUS, 32'h0000_0000);
      rd(12'h010, d, r);
      chk({r, d}, {`L1CC_RESP_SLVERR, 32'h0000_0000});
      $display("t_reset done");
   endtask
   task t_fetch;
      go(fe(1'b0, 1'b1), '0);
      chk({bus_o.valid, bus_o.bytes, cache_inhibit_out_o},
         8'h88);
      go(fe(1'b1, 1'b1), '0);
      chk({bus_o.valid, cache_inhibit_out_o}, 2'h3);
      $display("t_fetch done");
   endtask
   task t_lock;
      wr(`L1CC_OFF_CFG0, 32'h0000_0003);
      wr(`L1CC_OFF_L2CTL, 32'h0000_0001);
      go(fe(1'b0, 1'b0), '0);
      chk({bus_o.valid, bus_o.bytes, bus_o.fill_icache, bus_o.fill_l2},
         9'h180);
      wr(`L1CC_OFF_L2CTL, 32'h0000_0000);
      go(fe(1'b0, 1'b0), '0);
      chk({bus_o.valid, bus_o.fill_icache, bus_o.fill_l2}, 3'h5);
      go(fe(1'b0, 1'b1), '0);
      chk(bus_o.valid, 1'b0);
      rchk(`L1CC_OFF_STATUS, 32'h0000_0000);
      $display("t_lock done");
   endtask
   task t_icache_flash_invalidate_bit;
      int n;
      wr(`L1CC_OFF_CFG0, 32'h0000_0001);
      go(fe(1'b0, 1'b0), '0);
      chk({bus_o.bytes, bus_o.fill_icache}, 7'h41);
      @(posedge clk_i);
      soft_reset_i <= 1'b1;
      @(posedge clk_i);
      soft_reset_i <= 1'b0;
      rchk(`L1CC_OFF_STATUS, 32'h0000_0002);
      n = l1cc_sysbus_model_inst.n_req;
      wr(`L1CC_OFF_CFG0, 32'h0000_0005);
      rchk(`L1CC_OFF_CFG0, 32'h0000_0001);
      rchk(`L1CC_OFF_STATUS, 32'h0000_0000);
      chk(l1cc_sysbus_model_inst.n_req, n);
      wr(`L1CC_OFF_CFG0, 32'h0000_0004);
      rchk(`L1CC_OFF_CFG0, 32'h0000_0004);
      wr(`L1CC_OFF_CFG0, 32'h0000_0000);
      $display("t_icache_flash_invalidate_bit done");
   endtask
   task t_cmo;
      logic b;
      for (int op = 1; op <= 4; op++) begin
         for (int c = 0; c < 2; c++) begin
            b = (op == 4) || (c == 1);
            go('0, cm(l1cc_op_t'(op), c[0], 7'h30));
            chk({bus_o.valid, global_out_o & bus_o.valid},
               {b, b});
            go('0, cm(l1cc_op_t'(op), c[0], 7'h70));
            chk(bus_o.valid, 1'b0);
         end
      end
      $display("t_cmo done");
   endtask
   task t_touch;
      wr(`L1CC_OFF_CFG0, 32'h0000_0008);
      for (int i = 0; i < 7; i++)
         tch(TT[i][14:8], TT[i][5:0]);
      for (int j = 0; j < 3; j++) begin
         wr(`L1CC_OFF_CFG0, {24'h00_0000, TC[j][15:8]});
         tch(7'h30, TC[j][5:0]);
      end
      $display("t_touch done");
   endtask
   task t_flush;
      logic [31:0] d;
      logic [1:0] r;
      int k, n;
      dc_valid_i <= '1;
      dc_mod_i <= '1;
      wr(`L1CC_OFF_MEMSYS0, 32'h0000_0000);
      chk(dc_line_inv_o, 1'b0);
      n = l1cc_sysbus_model_inst.n_kill;
      // Software side: no interrupts or streams here, barrier is the response
      wr(`L1CC_OFF_MEMSYS0, 32'h0000_0001);
      dc_req_i <= 1'b1;
      snoop_cmd <= 1'b1;
      @(posedge clk_i);
      snoop_cmd <= 1'b0;
      #1;
      chk({dc_stall_o, snoop_take_o}, 2'h3);
      wr(`L1CC_OFF_MEMSYS0, 32'h0000_0001);
      k = 0;
      do begin
         rd(`L1CC_OFF_MEMSYS0, d, r);
         k++;
      end while (d[0] !== 1'b0 && k < 600);
      chk(d[0], 1'b0);
      chk(l1cc_sysbus_model_inst.n_kill - n, 1024);
      rd(`L1CC_OFF_STATUS, d, r);
      chk({dc_stall_o, d[0]}, 2'h0);
      dc_req_i <= 1'b0;
      // The walk has invalidated every line of the modelled array
      dc_valid_i <= '0;
      dc_mod_i <= '0;
      $display("t_flush done");
   endtask
   task t_hard;
      wr(`L1CC_OFF_CFG0, 32'h0000_0001);
      go(fe(1'b0, 1'b0), '0);
      reset_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      rchk(`L1CC_OFF_STATUS, 32'h0000_0000);
      rchk(`L1CC_OFF_CFG0, 32'h0000_0000);
      $display("t_hard done");
   endtask
   initial begin
      #500000;
      errors++;
      conclude;
   end
   initial begin
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      t_reset;
      t_fetch;
      t_lock;
      t_icache_flash_invalidate_bit;
      t_cmo;
      t_touch;
      t_flush;
      t_hard;
      conclude;
   end
endmodule
